// *** rtl/modem_status_pkg.sv ***
// constants for the modem status tracking block
package modem_status_pkg;
	localparam logic [11:0] modem_line_status_off     = 12'h000;
	localparam logic [11:0] handshake_control_reg_off = 12'h004;
	localparam logic [11:0] irq_status_off            = 12'h008;
	localparam logic [11:0] irq_enable_off            = 12'h00c;
	localparam logic [11:0] irq_clear_off             = 12'h010;
	localparam int          addr_w                    = 12;
	localparam int          loopback_bit              = 4;
	localparam logic [4:0]  handshake_control_reset   = 5'h00;
	localparam logic [3:0]  flags_reset               = 4'h0;
	localparam logic [3:0]  pins_idle_n               = 4'hf;
	localparam int          cts_pos                   = 0;
	localparam int          dsr_pos                   = 1;
	localparam int          ring_pos                  = 2;
	localparam int          carrier_pos               = 3;
	localparam int          irq_modem_pos             = 0;
	localparam logic [7:0]  irq_reset                 = 8'h00;
endpackage : modem_status_pkg

// *** rtl/sync_two_ff.sv ***
// two flip-flop synchroniser, one bit
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
	parameter logic idle_level = 1'b1  // level held through reset
) (
	input  wire logic pclk,     // clock
	input  wire logic presetn,  // async reset, active low
	input  wire logic d,        // async input
	output logic      q         // synchronised output
);
	logic meta_reg;
	logic meta_next;
	logic q_next;
	always_comb begin
		meta_next = d;
		q_next    = meta_reg;
	end
	// reset to the idle level so release shows no false edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= idle_level;
			q        <= idle_level;
		end else begin
			meta_reg <= meta_next;
			q        <= q_next;
		end
	end
endmodule : sync_two_ff
`default_nettype wire

// *** rtl/modem_status_tracking.sv ***
// modem status register with change flags, loop-back and apb access
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module modem_status_tracking (
	input  wire logic                             pclk,          // apb clock 10 MHz
	input  wire logic                             presetn,       // async reset, active low
	input  wire logic                             psel,          // apb select
	input  wire logic                             penable,       // apb enable
	input  wire logic                             pwrite,        // apb direction
	input  wire logic [modem_status_pkg::addr_w-1:0] paddr,      // apb byte address
	input  wire logic [31:0]                      pwdata,        // apb write data
	output logic      [31:0]                      prdata,        // apb read data
	output logic                                  pready,        // apb ready
	output logic                                  pslverr,       // apb error
	input  wire logic                             cts_in_n,      // clear to send, low active
	input  wire logic                             dsr_in_n,      // data set ready, low active
	input  wire logic                             ring_indicator_in_n,  // ring, low active
	input  wire logic                             carrier_detect_in_n,  // carrier, low active
	output logic                                  modem_irq_req, // modem status request
	output logic                                  irq            // masked interrupt level
);
	import modem_status_pkg::*;

	// ****************************************************************
	// input synchronisers
	// ****************************************************************
	logic [3:0] pins_n;
	logic [3:0] pins_sync_n;
	assign pins_n[cts_pos]     = cts_in_n;
	assign pins_n[dsr_pos]     = dsr_in_n;
	assign pins_n[ring_pos]    = ring_indicator_in_n;
	assign pins_n[carrier_pos] = carrier_detect_in_n;

	// every pin passes two flops before any logic reads it
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sync
			sync_two_ff #(.idle_level(pins_idle_n[gi])) u_sync (
				.pclk    (pclk),
				.presetn (presetn),
				.d       (pins_n[gi]),
				.q       (pins_sync_n[gi])
			);
		end
	endgenerate

	// ****************************************************************
	// apb decode
	// ****************************************************************
	logic access;
	logic wr_en;
	logic rd_en;
	assign access = psel && penable;
	assign wr_en  = access && pwrite;
	assign rd_en  = access && !pwrite;

	// write data above bit 7 has no storage behind it
	logic unused_wdata;
	assign unused_wdata = ^pwdata[31:8];

	logic hit_status;
	logic hit_control;
	logic hit_irq_status;
	logic hit_irq_enable;
	logic hit_irq_clear;
	logic hit_any;
	always_comb begin
		hit_status     = 1'b0;
		hit_control    = 1'b0;
		hit_irq_status = 1'b0;
		hit_irq_enable = 1'b0;
		hit_irq_clear  = 1'b0;
		if (paddr == modem_line_status_off) begin
			hit_status = 1'b1;
		end else if (paddr == handshake_control_reg_off) begin
			hit_control = 1'b1;
		end else if (paddr == irq_status_off) begin
			hit_irq_status = 1'b1;
		end else if (paddr == irq_enable_off) begin
			hit_irq_enable = 1'b1;
		end else if (paddr == irq_clear_off) begin
			hit_irq_clear = 1'b1;
		end
	end
	// an unmapped offset hits nothing and is answered with an error
	assign hit_any = hit_status | hit_control | hit_irq_status | hit_irq_enable | hit_irq_clear;

	// ****************************************************************
	// modem control, loop-back and live state
	// ****************************************************************
	logic [4:0] handshake_control_reg;
	logic [4:0] handshake_control_next;
	logic [3:0] prev_sync_n_reg;
	logic [3:0] prev_sync_n_next;
	logic [3:0] flags_reg;
	logic [3:0] flags_next;
	logic [3:0] live;
	logic [3:0] edge_set;
	logic       loopback;

	assign loopback = handshake_control_reg[loopback_bit];

	always_comb begin
		handshake_control_next = handshake_control_reg;
		if (wr_en && hit_control) begin
			handshake_control_next = pwdata[4:0];
		end
	end

	// leaving loop-back compares the pins with the looped history and may flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			handshake_control_reg <= handshake_control_reset;
		end else begin
			handshake_control_reg <= handshake_control_next;
		end
	end

	// live state, bit order cts, dsr, ring, carrier
	always_comb begin
		if (loopback) begin
			live[carrier_pos] = handshake_control_reg[3];
			live[ring_pos]    = handshake_control_reg[2];
			live[dsr_pos]     = handshake_control_reg[0];
			live[cts_pos]     = handshake_control_reg[1];
		end else begin
			live = ~pins_sync_n;
		end
	end

	// change detection on the live view so loop-back changes are seen too
	logic [3:0] live_prev;
	assign live_prev = ~prev_sync_n_reg;
	always_comb begin
		prev_sync_n_next = ~live;
		edge_set[carrier_pos] = live[carrier_pos] ^ live_prev[carrier_pos];
		edge_set[dsr_pos]     = live[dsr_pos] ^ live_prev[dsr_pos];
		edge_set[cts_pos]     = live[cts_pos] ^ live_prev[cts_pos];
		// ring input low to high means the live bit falls
		edge_set[ring_pos]    = live_prev[ring_pos] & ~live[ring_pos];
	end

	// history resets to idle so pins resting idle at release give no edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_sync_n_reg <= pins_idle_n;
		end else begin
			prev_sync_n_reg <= prev_sync_n_next;
		end
	end

	// ****************************************************************
	// change flags
	// ****************************************************************
	// set wins over the read clear
	always_comb begin
		flags_next = flags_reg;
		if (rd_en && hit_status) begin
			flags_next = flags_reset;
		end
		flags_next = flags_next | edge_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg <= flags_reset;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// ****************************************************************
	// interrupt status, enable, clear
	// ****************************************************************
	logic [7:0] irq_status_reg;
	logic [7:0] irq_status_next;
	logic [7:0] irq_enable_reg;
	logic [7:0] irq_enable_next;
	logic       modem_irq_next;
	logic       irq_next;
	logic       modem_event;

	assign modem_event = |edge_set;

	always_comb begin
		irq_status_next = irq_status_reg;
		if (wr_en && hit_irq_clear) begin
			irq_status_next = irq_status_reg & ~pwdata[7:0];
		end
		// set after the clear so an event in the clear cycle survives
		if (modem_event) begin
			irq_status_next[irq_modem_pos] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_reg <= irq_reset;
		end else begin
			irq_status_reg <= irq_status_next;
		end
	end

	always_comb begin
		irq_enable_next = irq_enable_reg;
		if (wr_en && hit_irq_enable) begin
			irq_enable_next = pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg <= irq_reset;
		end else begin
			irq_enable_reg <= irq_enable_next;
		end
	end

	// ****************************************************************
	// interrupt request outputs
	// ****************************************************************
	// next values keep both requests in step with the flags and status
	always_comb begin
		modem_irq_next = |flags_next;
		irq_next       = |(irq_status_next & irq_enable_next);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_irq_req <= 1'b0;
			irq           <= 1'b0;
		end else begin
			modem_irq_req <= modem_irq_next;
			irq           <= irq_next;
		end
	end

	// ****************************************************************
	// read data
	// ****************************************************************
	logic [7:0]  status_word;
	assign status_word = {live[carrier_pos], live[ring_pos], live[dsr_pos], live[cts_pos],
		flags_next};

	logic [31:0] prdata_next;
	logic        pslverr_next;
	logic        pready_next;
	// read data is latched in the setup cycle, so the access phase needs no wait
	always_comb begin
		prdata_next  = 32'h0000_0000;
		pslverr_next = 1'b0;
		pready_next  = psel && !penable;
		if (psel && !penable && !pwrite) begin
			if (hit_status) begin
				prdata_next[7:0] = status_word;
			end else if (hit_control) begin
				prdata_next[4:0] = handshake_control_reg;
			end else if (hit_irq_status) begin
				prdata_next[7:0] = irq_status_reg;
			end else if (hit_irq_enable) begin
				prdata_next[7:0] = irq_enable_reg;
			end
		end else if (access) begin
			prdata_next = prdata;
		end
		if (psel && !penable) begin
			pslverr_next = !hit_any;
		end else if (access) begin
			pslverr_next = pslverr;
		end
	end

	// ****************************************************************
	// apb response registers
	// ****************************************************************
	// pready stands for the access phase only; penable high drops it again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready  <= 1'b0;
		end else begin
			prdata  <= prdata_next;
			pslverr <= pslverr_next;
			pready  <= pready_next;
		end
	end
endmodule : modem_status_tracking
`default_nettype wire

// *** tb/modem_peer.sv ***
// modem side model driving the four low-active handshake lines
`timescale 1ns/1ps
`default_nettype none
module modem_peer (
	input  wire logic      pclk,    // bench clock
	output var logic [3:0] lines_n  // carrier, ring, dsr, cts; idle high
);
	initial lines_n = 4'hf;
	// moves only just after an edge, so no line changes twice in a step
	task automatic set_lines(input logic [3:0] v);
		@(posedge pclk);
		lines_n <= v;
	endtask : set_lines
endmodule : modem_peer
`default_nettype wire

// *** tb/modem_status_tracking_chk.sv ***
// assertion checker for the modem status block
`timescale 1ns/1ps
`default_nettype none
module modem_status_tracking_chk
	import modem_status_pkg::*;
(
	input wire logic        pclk,                // clock
	input wire logic        presetn,             // reset, active low
	input wire logic        psel,                // apb select
	input wire logic        penable,             // apb enable
	input wire logic        pwrite,              // apb direction
	input wire logic [11:0] paddr,               // apb address
	input wire logic [31:0] pwdata,              // apb write data
	input wire logic [31:0] prdata,              // apb read data
	input wire logic        pready,              // apb ready
	input wire logic        pslverr,             // apb error
	input wire logic        cts_in_n,            // cts pin
	input wire logic        dsr_in_n,            // dsr pin
	input wire logic        ring_indicator_in_n, // ring pin
	input wire logic        carrier_detect_in_n, // carrier pin
	input wire logic        modem_irq_req        // change request
);
	logic [3:0] q_reg, q_next, p_reg, pins;
	logic [4:0] c_reg, c_next;
	logic       rd0;
	assign pins = {carrier_detect_in_n, ring_indicator_in_n, dsr_in_n, cts_in_n};
	assign rd0 = pready && !pwrite && paddr == modem_line_status_off;
	// q counts quiet cycles; live checks wait until syncs have settled
	always_comb begin
		c_next = c_reg;
		q_next = (q_reg == 4'hf) ? q_reg : q_reg + 4'h1;
		if (pins != p_reg)
			q_next = 4'h0;
		if (pready && pwrite && paddr == handshake_control_reg_off) begin
			c_next = pwdata[4:0];
			q_next = 4'h0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_reg <= 4'h0;
			c_reg <= 5'h00;
			p_reg <= pins_idle_n;
		end else begin
			q_reg <= q_next;
			c_reg <= c_next;
			p_reg <= pins;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_in_access_a: assert property (psel && !penable |=> pready) else $error("no ready");
	ready_only_access_a: assert property (pready |-> psel && penable) else $error("stray ready");
	err_decode_a: assert property (pready |-> pslverr == !(paddr inside {12'h000, 12'h004,
		12'h008, 12'h00c, 12'h010})) else $error("bad error response");
	req_matches_a: assert property (rd0 |-> modem_irq_req == (prdata[3:0] != 4'h0))
		else $error("request disagrees with flags");
	read_clears_a: assert property (rd0 && q_reg > 4'h5 |=> !modem_irq_req)
		else $error("flags survive a read");
	live_pins_a: assert property (rd0 && !c_reg[4] && q_reg > 4'h5 |-> prdata[7:4] == ~pins)
		else $error("live bits wrong");
	live_loop_a: assert property (rd0 && c_reg[4] && q_reg > 4'h5 |->
		prdata[7:4] == {c_reg[3], c_reg[2], c_reg[0], c_reg[1]}) else $error("loop bits wrong");
	pin_flag_a: assert property (!c_reg[4] && ((pins ^ p_reg) & 4'hb) != 4'h0 |-> ##[1:4] modem_irq_req)
		else $error("change not flagged");
	ring_rise_a: assert property (!c_reg[4] && pins[2] && !p_reg[2] |-> ##[1:4] modem_irq_req)
		else $error("ring edge not flagged");
endmodule : modem_status_tracking_chk
bind modem_status_tracking modem_status_tracking_chk u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cts_in_n, .dsr_in_n,
	.ring_indicator_in_n, .carrier_detect_in_n, .modem_irq_req);
`default_nettype wire

// *** tb/test_modem_status_tracking.sv ***
// self-checking bench for the modem status tracking block
`timescale 1ns/1ps
`default_nettype none
module test_modem_status_tracking;
	import modem_status_pkg::*;
	logic        pclk = 0, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, req, irq, er;
	logic [3:0]  ln;
	int          errors = 0, n_checks = 0;
	int          pos[3] = '{0, 1, 3};
	always #50 pclk = ~pclk;
	modem_peer u_peer (.pclk(pclk), .lines_n(ln));
	modem_status_tracking DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cts_in_n(ln[0]), .dsr_in_n(ln[1]), .ring_indicator_in_n(ln[2]),
		.carrier_detect_in_n(ln[3]), .modem_irq_req(req), .irq(irq));
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// signals move right after a rising edge; ready and data are taken on a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			errors++;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read data", e, rd);
	endtask : rdc
	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask : idle
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		repeat (3000) @(posedge pclk);
		errors++;
		tally_and_finish();
	end
	initial begin
		presetn <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0000_0000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(negedge pclk);
		chk("request", 32'h0, req);
		rdc(modem_line_status_off, 32'h0);
		rdc(handshake_control_reg_off, 32'h0);
		rdc(irq_enable_off, 32'h0);
		rdc(irq_clear_off, 32'h0);
		foreach (pos[i]) begin
			u_peer.set_lines(4'hf & ~(4'h1 << pos[i]));
			idle(6);
			rdc(modem_line_status_off, 32'h11 << pos[i]);
			rdc(modem_line_status_off, 32'h10 << pos[i]);
			u_peer.set_lines(4'hf);
			idle(6);
			rdc(modem_line_status_off, 32'h01 << pos[i]);
		end
		u_peer.set_lines(4'hb);
		idle(6);
		rdc(modem_line_status_off, 32'h40);
		u_peer.set_lines(4'hf);
		idle(6);
		rdc(modem_line_status_off, 32'h04);
		apb(1'b1, irq_enable_off, 32'h1);
		u_peer.set_lines(4'he);
		idle(6);
		@(negedge pclk);
		chk("request", 32'h1, req);
		chk("irq", 32'h1, irq);
		rdc(irq_status_off, 32'h1);
		rdc(modem_line_status_off, 32'h11);
		@(negedge pclk);
		chk("request", 32'h0, req);
		chk("irq", 32'h1, irq);
		apb(1'b1, irq_clear_off, 32'h1);
		@(negedge pclk);
		chk("irq", 32'h0, irq);
		apb(1'b1, irq_enable_off, 32'h0);
		u_peer.set_lines(4'hf);
		idle(6);
		@(negedge pclk);
		chk("masked irq", 32'h0, irq);
		rdc(modem_line_status_off, 32'h01);
		rdc(12'h020, 32'h0);
		chk("error", 32'h1, er);
		apb(1'b1, 12'h024, 32'h1);
		chk("error", 32'h1, er);
		apb(1'b1, handshake_control_reg_off, 32'h1f);
		idle(4);
		rdc(handshake_control_reg_off, 32'h1f);
		rdc(modem_line_status_off, 32'hfb);
		apb(1'b1, handshake_control_reg_off, 32'h16);
		idle(4);
		rdc(modem_line_status_off, 32'h5a);
		u_peer.set_lines(4'h0);
		idle(6);
		rdc(modem_line_status_off, 32'h50);
		tally_and_finish();
	end
endmodule : test_modem_status_tracking
`default_nettype wire
